/* File: bench/board_side_model.sv */
// board-side model: reset pin, mode straps and watchdog overflow source
`timescale 1ns/100ps
`default_nettype none
module board_side_model (
  input  wire logic mclk,
  output var  logic chip_clear_n,
  output var  logic wdt_overflow,
  output var  logic mode_pin_high,
  output var  logic mode_pin_low
);
  // power-on: reset pin held low, straps at single-chip
  initial begin
    chip_clear_n  = 1'b0;
    wdt_overflow  = 1'b0;
    mode_pin_high = 1'b1;
    mode_pin_low  = 1'b1;
  end

  // strap a mode and drive the reset pin low on the same edge, holding it low for at least ten clocks
  task automatic pin_reset(input logic [1:0] mode, input int cycles);
    int n;
    n = (cycles < 10) ? 10 : cycles;
    @(posedge mclk);
    chip_clear_n  <= 1'b0;
    mode_pin_high <= (mode == 2'b00) ? 1'b1 : mode[1];
    mode_pin_low  <= (mode == 2'b00) ? 1'b1 : mode[0];
    repeat (n) @(posedge mclk);
    chip_clear_n  <= 1'b1;
  endtask

  // one-cycle overflow pulse with the reset option selected
  task automatic wdt_fire;
    @(posedge mclk);
    wdt_overflow <= 1'b1;
    @(posedge mclk);
    wdt_overflow <= 1'b0;
  endtask
endmodule // board_side_model
`default_nettype wire

/* File: bench/test_mode_sysctrl_reset_seq.sv */
// self-checking bench for the mode, system control and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module test_mode_sysctrl_reset_seq;
  localparam logic [15:0] CTL = 16'hFFC4;
  localparam logic [15:0] STAT = 16'hFFC5;
  localparam logic [3:0] SLP = 4'h8;
  localparam logic [3:0] WAK = 4'h4;
  localparam logic [3:0] INS = 4'h2;
  localparam logic [3:0] CCM = 4'h1;
  logic                   mclk, arst_n, nmi_pin, sleep_exec, wake_irq, instr_end, cc_manip_end;
  logic [15:0]            reg_addr, reset_vec_addr;
  logic [7:0]             reg_wdata, reg_rdata;
  logic                   reg_wr, reg_rd, chip_clear_n, wdt_overflow, mode_pin_high, mode_pin_low;
  logic                   chip_reset, wdt_pulse, reset_vec_fetch, ccr_imask_set, irq_window;
  logic                   nmi_take, sleep_mode, sw_standby, settle_hold, ext_ram_route;
  logic                   onchip_ram_enable, host_port_enable;
  sysctrl_pkg::mode_ctl_s mode_ctl;
  int                     failures, check_count, n;
  int                     settle_tab [8] = '{20, 24, 28, 32, 40, 40, 32, 4};
  logic [3:0]             mode_tab [4] = '{4'b0001, 4'b1000, 4'b1100, 4'b0110};

  // device under test with shortened settling counts
  mode_sysctrl_reset_seq #(.SETTLE_C0(20), .SETTLE_C1(24), .SETTLE_C2(28), .SETTLE_C3(32),
    .SETTLE_C4(40)) dut_u (.mclk, .arst_n, .chip_clear_n, .wdt_overflow, .mode_pin_high,
    .mode_pin_low, .nmi_pin, .sleep_exec, .wake_irq, .instr_end, .cc_manip_end, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chip_reset, .wdt_pulse, .reset_vec_fetch,
    .reset_vec_addr, .ccr_imask_set, .irq_window, .nmi_take, .sleep_mode, .sw_standby,
    .settle_hold, .mode_ctl, .ext_ram_route, .onchip_ram_enable, .host_port_enable);

  // board side: reset pin, straps, watchdog
  board_side_model board_u (.mclk, .chip_clear_n, .wdt_overflow, .mode_pin_high,
    .mode_pin_low);

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // one-cycle cpu event pulse, sampled after the taking edge
  task automatic pulse(input logic [3:0] s);
    @(posedge mclk);
    {sleep_exec, wake_irq, instr_end, cc_manip_end} <= s;
    @(posedge mclk);
    {sleep_exec, wake_irq, instr_end, cc_manip_end} <= 4'h0;
    #1;
  endtask

  task automatic await_vec;
    int k;
    k = 0;
    while (reset_vec_fetch !== 1'b1 && k < 40) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(reset_vec_fetch, 1'b1);
    chk(ccr_imask_set, 1'b1);
    chk(reset_vec_addr, 16'h0000);
    chk(chip_reset, 1'b0);
  endtask

  // length of a high stretch of the watchdog pulse or the settling hold
  task automatic count_hi(input bit use_wdt, output int c);
    c = 0;
    while ((use_wdt ? wdt_pulse : settle_hold) === 1'b1 && c < 1000) begin
      @(posedge mclk);
      #1;
      c++;
    end
  endtask

  task automatic test_done;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run of about a thousand cycles
  initial begin
    #300000;
    failures++;
    test_done;
  end

  // main sequence
  initial begin
    arst_n = 1'b0;
    nmi_pin = 1'b1;
    {sleep_exec, wake_irq, instr_end, cc_manip_end} = 4'h0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    rd(CTL, 8'h09);
    for (int m = 1; m < 4; m++) begin
      board_u.pin_reset(m[1:0], 12);
      await_vec;
      chk(mode_ctl, mode_tab[m]);
      rd(STAT, 8'hE4 | m[7:0]);
      wr(STAT, 8'h00);
      rd(STAT, 8'hE4 | m[7:0]);
      rd(16'hFFC6, 8'h00);
      wr(CTL, 8'h02);
      @(posedge mclk);
      #1;
      chk(host_port_enable, 1'b1);
      chk(onchip_ram_enable, 1'b0);
      chk(ext_ram_route, m != 3);
      wr(CTL, 8'hF7);
      rd(CTL, 8'hFF);
    end
    pulse(INS);
    chk(irq_window, 1'b0);
    pulse(INS);
    chk(irq_window, 1'b1);
    pulse(INS | CCM);
    chk(irq_window, 1'b0);
    pulse(INS);
    chk(irq_window, 1'b1);
    // both edge selects against both pin edges
    for (int i = 0; i < 4; i++) begin
      wr(CTL, {5'h00, i[1], 2'b01});
      @(posedge mclk);
      nmi_pin <= i[0];
      repeat (4) @(posedge mclk);
      pulse(INS);
      chk(nmi_take, i[1] == i[0]);
    end
    wr(CTL, 8'h01);
    pulse(SLP);
    chk({sleep_mode, sw_standby}, 2'b10);
    pulse(WAK);
    chk(sleep_mode, 1'b0);
    // every settling code from software standby
    for (int c = 0; c < 8; c++) begin
      wr(CTL, {1'b1, c[2:0], 4'h0});
      pulse(SLP);
      chk(sw_standby, 1'b1);
      pulse(WAK);
      count_hi(1'b0, n);
      chk(n, settle_tab[c]);
      chk(onchip_ram_enable, 1'b0);
      rd(CTL, {1'b1, c[2:0], 4'h8});
    end
    wr(CTL, 8'h06);
    board_u.wdt_fire;
    #1;
    chk(chip_reset, 1'b1);
    count_hi(1'b1, n);
    chk(n, 518);
    await_vec;
    rd(CTL, 8'h01);
    chk(host_port_enable, 1'b0);
    pulse(INS);
    chk(irq_window, 1'b0);
    test_done;
  end
endmodule // test_mode_sysctrl_reset_seq
`default_nettype wire

/* File: hw/mode_sysctrl_reset_seq.sv */
// mode decode, system control register and reset exception sequencer
`timescale 1ns/100ps
`default_nettype none
module mode_sysctrl_reset_seq #(
  parameter int SETTLE_C0 = 8192,
  parameter int SETTLE_C1 = 16384,
  parameter int SETTLE_C2 = 32768,
  parameter int SETTLE_C3 = 65536,
  parameter int SETTLE_C4 = 131072
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              chip_clear_n,
  input  wire logic              wdt_overflow,
  input  wire logic              mode_pin_high,
  input  wire logic              mode_pin_low,
  input  wire logic              nmi_pin,
  input  wire logic              sleep_exec,
  input  wire logic              wake_irq,
  input  wire logic              instr_end,
  input  wire logic              cc_manip_end,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [7:0]        reg_rdata,
  output var  logic              chip_reset,
  output var  logic              wdt_pulse,
  output var  logic              reset_vec_fetch,
  output var  logic [15:0]       reset_vec_addr,
  output var  logic              ccr_imask_set,
  output var  logic              irq_window,
  output var  logic              nmi_take,
  output var  logic              sleep_mode,
  output var  logic              sw_standby,
  output var  logic              settle_hold,
  output var  sysctrl_pkg::mode_ctl_s mode_ctl,
  output var  logic              ext_ram_route,
  output var  logic              onchip_ram_enable,
  output var  logic              host_port_enable
);

  // synchronised pins: clear, mode high, mode low, nmi
  logic [3:0] pins_s;
  sync_2ff #(.W(4)) u_pin_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({chip_clear_n, mode_pin_high, mode_pin_low, nmi_pin}),
    .q      (pins_s)
  );

  wire logic clear_n_s = pins_s[3];
  wire logic mode_hi_s = pins_s[2];
  wire logic mode_lo_s = pins_s[1];
  wire logic nmi_s     = pins_s[0];

  sysctrl_pkg::seq_state_e state_reg;
  sysctrl_pkg::seq_state_e state_next;
  logic [sysctrl_pkg::CNT_W-1:0] cnt_reg;
  logic [sysctrl_pkg::CNT_W-1:0] cnt_next;
  logic [sysctrl_pkg::CNT_W-1:0] settle_load;
  logic [7:0] sysctrl_reg;
  logic       pin_flag_reg;
  logic [1:0] mode_code_reg;
  logic [1:0] mode_latch_reg;
  logic       nmi_prev_reg;
  logic       nmi_pend_reg;

  // register decode
  wire logic sel_sys  = reg_addr == sysctrl_pkg::SYSCTRL_ADDR;
  wire logic sel_mode = reg_addr == sysctrl_pkg::MODESTAT_ADDR;
  wire logic wr_sys   = reg_wr && sel_sys;
  wire logic rd_mode  = reg_rd && sel_mode;
  wire logic rd_sys   = reg_rd && sel_sys;
  wire logic [7:0] sys_view = {sysctrl_reg[7:4], pin_flag_reg, sysctrl_reg[2:0]};
  wire logic [7:0] mode_view = sysctrl_pkg::MODESTAT_FIXED | {6'h00, mode_hi_s, mode_lo_s};

  // control fields
  wire logic       standby_on_sleep  = sysctrl_reg[sysctrl_pkg::BIT_STANDBY];
  wire logic [2:0] settle_sel        = sysctrl_reg[sysctrl_pkg::BIT_SETTLE_LO +: 3];
  wire logic       nmi_edge_select   = sysctrl_reg[sysctrl_pkg::BIT_NMI_EDGE];
  wire logic       onchip_ram_en_bit = sysctrl_reg[sysctrl_pkg::BIT_RAM_EN];

  // reset states and state-entry strobes
  wire logic in_reset_next = (state_next == sysctrl_pkg::ST_HOLD) ||
                             (state_next == sysctrl_pkg::ST_WDT);
  wire logic enter_wdt     = (state_next == sysctrl_pkg::ST_WDT) &&
                             (state_reg != sysctrl_pkg::ST_WDT);
  wire logic enter_settle  = (state_next == sysctrl_pkg::ST_SETTLE) &&
                             (state_reg != sysctrl_pkg::ST_SETTLE);

  // interrupt acceptance only at an ordinary instruction end while running
  wire logic win_now = (state_reg == sysctrl_pkg::ST_RUN) && instr_end &&
                       !cc_manip_end;

  // nmi edge per selected polarity
  wire logic nmi_edge = nmi_edge_select ? (nmi_s && !nmi_prev_reg)
                                        : (!nmi_s && nmi_prev_reg);
  wire logic nmi_take_now = win_now && nmi_pend_reg;

  // counter width as a local short name for the sized casts below
  localparam int CNT_W = sysctrl_pkg::CNT_W;

  // settling length for the coded field, minus one for the down counter
  always_comb begin
    case (settle_sel)
      3'h0:    settle_load = CNT_W'(SETTLE_C0 - 1);
      3'h1:    settle_load = CNT_W'(SETTLE_C1 - 1);
      3'h2:    settle_load = CNT_W'(SETTLE_C2 - 1);
      3'h3:    settle_load = CNT_W'(SETTLE_C3 - 1);
      3'h4,
      3'h5:    settle_load = CNT_W'(SETTLE_C4 - 1);
      3'h6:    settle_load = CNT_W'(sysctrl_pkg::SETTLE_SHORT - 1);
      3'h7:    settle_load = CNT_W'(sysctrl_pkg::SETTLE_SHORTEST - 1);
      default: settle_load = CNT_W'(SETTLE_C0 - 1);
    endcase
  end

  // sequencer: pin reset first, then watchdog reset, then normal flow
  always_comb begin
    state_next = state_reg;
    if (!clear_n_s) begin
      state_next = sysctrl_pkg::ST_HOLD;
    end else if (wdt_overflow && state_reg != sysctrl_pkg::ST_HOLD &&
                 state_reg != sysctrl_pkg::ST_WDT) begin
      state_next = sysctrl_pkg::ST_WDT;
    end else begin
      case (state_reg)
        sysctrl_pkg::ST_HOLD:   state_next = sysctrl_pkg::ST_VEC;
        sysctrl_pkg::ST_WDT: begin
          if (cnt_reg == '0) state_next = sysctrl_pkg::ST_VEC;
        end
        sysctrl_pkg::ST_VEC:    state_next = sysctrl_pkg::ST_FIRST;
        sysctrl_pkg::ST_FIRST: begin
          if (instr_end) state_next = sysctrl_pkg::ST_RUN;
        end
        sysctrl_pkg::ST_RUN: begin
          if (sleep_exec) begin
            state_next = standby_on_sleep ? sysctrl_pkg::ST_STBY
                                          : sysctrl_pkg::ST_SLEEP;
          end
        end
        sysctrl_pkg::ST_SLEEP: begin
          if (wake_irq) state_next = sysctrl_pkg::ST_RUN;
        end
        sysctrl_pkg::ST_STBY: begin
          if (wake_irq) state_next = sysctrl_pkg::ST_SETTLE;
        end
        sysctrl_pkg::ST_SETTLE: begin
          if (cnt_reg == '0) state_next = sysctrl_pkg::ST_RUN;
        end
        default:                state_next = sysctrl_pkg::ST_HOLD;
      endcase
    end
  end

  // shared down counter for the watchdog pulse and the settling wait
  always_comb begin
    if (enter_wdt) begin
      cnt_next = CNT_W'(sysctrl_pkg::WDT_PULSE_CYC - 1);
    end else if (enter_settle) begin
      cnt_next = settle_load;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // state and counter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= sysctrl_pkg::ST_HOLD;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // system control register; reset restores it, standby leaves it alone
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sysctrl_reg <= sysctrl_pkg::SYSCTRL_RESET;
    end else if (in_reset_next) begin
      sysctrl_reg <= sysctrl_pkg::SYSCTRL_RESET;
    end else if (wr_sys) begin
      sysctrl_reg <= (reg_wdata & sysctrl_pkg::SYSCTRL_WR_MASK) |
                     (sysctrl_reg & ~sysctrl_pkg::SYSCTRL_WR_MASK);
    end
  end

  // reset source flag, never written by software
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_flag_reg <= 1'b1;
    end else if (state_next == sysctrl_pkg::ST_HOLD) begin
      pin_flag_reg <= 1'b1;
    end else if (enter_wdt) begin
      pin_flag_reg <= 1'b0;
    end
  end

  // straps captured while the reset pin holds the chip in reset; a watchdog reset keeps them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_code_reg <= 2'h3;
    end else if (state_reg == sysctrl_pkg::ST_HOLD) begin
      mode_code_reg <= {mode_hi_s, mode_lo_s};
    end
  end

  // mode register read latches the live pin levels
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_latch_reg <= 2'h0;
    end else if (rd_mode) begin
      mode_latch_reg <= {mode_hi_s, mode_lo_s};
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (rd_sys) begin
      reg_rdata <= sys_view;
    end else if (rd_mode) begin
      reg_rdata <= mode_view;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // nmi edge capture; a new edge wins over the take
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_prev_reg <= 1'b0;
      nmi_pend_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_s;
      if (in_reset_next) begin
        nmi_pend_reg <= 1'b0;
      end else begin
        nmi_pend_reg <= nmi_edge || (nmi_pend_reg && !nmi_take_now);
      end
    end
  end

  // sequencer outputs
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chip_reset      <= 1'b1;
      wdt_pulse       <= 1'b0;
      reset_vec_fetch <= 1'b0;
      reset_vec_addr  <= 16'h0000;
      ccr_imask_set   <= 1'b0;
      sleep_mode      <= 1'b0;
      sw_standby      <= 1'b0;
      settle_hold     <= 1'b0;
    end else begin
      chip_reset      <= in_reset_next;
      wdt_pulse       <= state_next == sysctrl_pkg::ST_WDT;
      reset_vec_fetch <= state_next == sysctrl_pkg::ST_VEC;
      reset_vec_addr  <= sysctrl_pkg::RESET_VEC_ADDR;
      ccr_imask_set   <= state_next == sysctrl_pkg::ST_VEC;
      sleep_mode      <= state_next == sysctrl_pkg::ST_SLEEP;
      sw_standby      <= state_next == sysctrl_pkg::ST_STBY;
      settle_hold     <= state_next == sysctrl_pkg::ST_SETTLE;
    end
  end

  // interrupt window and nmi acceptance pulses
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_window <= 1'b0;
      nmi_take   <= 1'b0;
    end else begin
      irq_window <= win_now && clear_n_s && !wdt_overflow;
      nmi_take   <= nmi_take_now && clear_n_s && !wdt_overflow;
    end
  end

  // mode and memory map controls
  wire logic code_exp = (mode_code_reg == 2'h1) || (mode_code_reg == 2'h2);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ctl          <= '0;
      ext_ram_route     <= 1'b0;
      onchip_ram_enable <= 1'b1;
      host_port_enable  <= 1'b0;
    end else begin
      mode_ctl.expanded    <= code_exp;
      mode_ctl.rom_en      <= mode_code_reg[1];
      mode_ctl.single_chip <= mode_code_reg == 2'h3;
      mode_ctl.invalid     <= mode_code_reg == 2'h0;
      ext_ram_route        <= code_exp && !onchip_ram_en_bit;
      onchip_ram_enable    <= onchip_ram_en_bit;
      host_port_enable     <= sysctrl_reg[sysctrl_pkg::BIT_HOST_EN];
    end
  end

  // helper: length of the current watchdog pulse
  logic [sysctrl_pkg::WLEN_W-1:0] wdt_len_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_len_reg <= '0;
    end else begin
      wdt_len_reg <= wdt_pulse ? wdt_len_reg + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence s_vec_entry;
    reset_vec_fetch && ccr_imask_set && !irq_window ##1
      !reset_vec_fetch && !irq_window && !nmi_take;
  endsequence

  a_reset_exit_vec: assert property ($fell(chip_reset) |-> s_vec_entry)
    else $error("reset exit without vector fetch");
  a_wdt_pulse_len: assert property (
    ($fell(wdt_pulse) && reset_vec_fetch) |-> wdt_len_reg == 10'h206)
    else $error("watchdog pulse length wrong");
  a_sleep_select: assert property (
    (state_reg == sysctrl_pkg::ST_RUN && sleep_exec && clear_n_s && !wdt_overflow)
      |=> (sleep_mode == !$past(standby_on_sleep)) && (sw_standby == $past(standby_on_sleep)))
    else $error("sleep target mismatch");
  a_standby_keep: assert property (
    (sw_standby && wake_irq && clear_n_s && !wdt_overflow) |=> ##1 settle_hold && standby_on_sleep)
    else $error("standby select lost on wake");
  a_flag_pin: assert property (
    !clear_n_s |=> pin_flag_reg ##1 (reg_rdata[3] || !$past(rd_sys)))
    else $error("pin reset flag not set");
  a_nmi_edge: assert property (
    (nmi_edge && !in_reset_next) |=> nmi_pend_reg)
    else $error("nmi edge not captured");
  a_mode_read: assert property (rd_mode |=> reg_rdata[7:2] == 6'h39 &&
    reg_rdata[1:0] == mode_latch_reg)
    else $error("mode register read wrong");
  a_first_blocked: assert property (
    (state_reg == sysctrl_pkg::ST_FIRST) |=> !irq_window && !nmi_take)
    else $error("interrupt during first instruction");
  a_cc_block: assert property (cc_manip_end |=> !irq_window && !nmi_take)
    else $error("interrupt after cc manipulation");
  a_ram_route: assert property (
    ext_ram_route == (!mode_ctl.single_chip && !mode_ctl.invalid && !onchip_ram_enable))
    else $error("ram routing wrong");
  a_host_follow: assert property (
    wr_sys && !in_reset_next |=> ##1 host_port_enable == $past(reg_wdata[1], 2))
    else $error("host port enable not following");

endmodule // mode_sysctrl_reset_seq
`default_nettype wire

/* File: hw/sync_2ff.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // sync_2ff
`default_nettype wire

/* File: hw/sysctrl_pkg.sv */
// constants, types and field layout of the mode and system control block
// Functional notes
// - mode pins decode to mode 1, 2 (expanded) or 3 (single-chip).
// - expanded modes open off-chip memory over a 64 kbyte address space.
// - mode 3 uses only on-chip memory and frees all ports as GPIO.
// - expanded mode with RAM enable at 0 sends RAM-range accesses off-chip.
// - 8-bit system control register at FFC4 holds the control fields.
// - sleep instruction enters sleep or software standby per bit 7.
// - waking from standby leaves bit 7 at 1; only software or a reset clears it.
// - standby wake holds CPU for the coded settling time in states.
// - read-only reset flag: 1 after pin reset, 0 after watchdog reset.
// - non-maskable request on falling edge, or rising when bit 2 set.
// - bit 1 enables the host interface as a slave.
// - bit 0 enables on-chip RAM; reset sets it, standby keeps it.
// - read-only mode register at FFC5 with fixed 1 and 0 bits.
// - each mode register read latches and returns the two mode pins.
// - reset outranks interrupts; interrupts seen only at instruction ends.
// - pin or watchdog reset stops processing and clears state; a watchdog reset keeps the strapped mode.
// - watchdog reset pulse lasts 518 clocks, then reset handling starts.
// - reset handling sets the mask bit and fetches the vector at 0000.
// - all interrupts blocked for the first instruction and after CC ops.
package sysctrl_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          CNT_W           = 18;
  localparam int          WLEN_W          = 10;
  localparam logic [15:0] SYSCTRL_ADDR    = 16'hFFC4;
  localparam logic [15:0] MODESTAT_ADDR   = 16'hFFC5;
  localparam logic [15:0] RESET_VEC_ADDR  = 16'h0000;
  localparam logic [7:0]  SYSCTRL_RESET   = 8'h09;
  localparam logic [7:0]  SYSCTRL_WR_MASK = 8'hF7;
  localparam logic [7:0]  MODESTAT_FIXED  = 8'hE4;
  localparam int          BIT_STANDBY     = 7;
  localparam int          BIT_SETTLE_LO   = 4;
  localparam int          BIT_PIN_FLAG    = 3;
  localparam int          BIT_NMI_EDGE    = 2;
  localparam int          BIT_HOST_EN     = 1;
  localparam int          BIT_RAM_EN      = 0;
  localparam int          WDT_PULSE_CYC   = 518;
  localparam int          SETTLE_SHORT    = 32;
  localparam int          SETTLE_SHORTEST = 4;

  typedef enum logic [7:0] {
    ST_HOLD   = 8'h01,
    ST_WDT    = 8'h02,
    ST_VEC    = 8'h04,
    ST_FIRST  = 8'h08,
    ST_RUN    = 8'h10,
    ST_SLEEP  = 8'h20,
    ST_STBY   = 8'h40,
    ST_SETTLE = 8'h80
  } seq_state_e;

  typedef struct packed {
    logic expanded;
    logic rom_en;
    logic single_chip;
    logic invalid;
  } mode_ctl_s;

endpackage
